// ==== bench/puc_drv.sv ====
`timescale 1ns/10ps
module puc_drv(input wire clk_sys,output reg [7:0] v=8'h00);
integer seed=32'hed5563ba;
always @(negedge clk_sys) v<=$random(seed);
endmodule // puc_drv

// ==== bench/puc_sva.sv ====
`timescale 1ns/10ps
module puc_sva(input wire clk_sys,reset_n,load_n,count_up,
  count_gate_parallel_n,count_gate_carry_n,terminal_flag_n,
  input wire [3:0] preset_inputs,count_value);
default clocking @(posedge clk_sys); endclocking
default disable iff (!reset_n);
load_copy_a: assert property(
  !load_n|=>count_value==$past(preset_inputs)) else $error("load");
par_hold_a: assert property(
  load_n&&count_gate_parallel_n|=>$stable(count_value)) else $error("hold");
carry_hold_a: assert property(
  load_n&&count_gate_carry_n|=>$stable(count_value)) else $error("carry");
count_up_a: assert property(
  load_n&&!count_gate_parallel_n&&!count_gate_carry_n&&count_up
  |=>count_value==$past(count_value)+4'h1) else $error("up");
count_down_a: assert property(
  load_n&&!count_gate_parallel_n&&!count_gate_carry_n&&!count_up
  |=>count_value==$past(count_value)-4'h1) else $error("down");
term_flag_a: assert property(
  terminal_flag_n==!(!count_gate_carry_n&&
  count_value==(count_up?4'hF:4'h0))) else $error("flag");
endmodule // puc_sva
bind puc_counter puc_sva puc_sva_inst(.*);

// ==== bench/tb_puc_counter.sv ====
`timescale 1ns/10ps
module tb_puc_counter;
reg clk_sys=0,reset_n=0;
reg [3:0] m=4'h0;
reg [3:0] x=4'h0;
wire [7:0] v;
wire [3:0] q;
wire t;
integer n_mismatch=0,n_checks=0;
logic [3:0] e[$];
always #12.5 clk_sys=~clk_sys;
puc_drv puc_drv_inst(.clk_sys(clk_sys),.v(v));
puc_counter puc_counter_inst(.clk_sys(clk_sys),.reset_n(reset_n),
  .load_n(v[0]),.count_gate_parallel_n(v[1]),.count_gate_carry_n(v[2]),
  .count_up(v[3]),.preset_inputs(v[7:4]),.count_value(q),.terminal_flag_n(t));
task chk(input string name,input [3:0] s,input [3:0] w);
  n_checks++;
  if (s!==w) n_mismatch++;
  if (s!==w) $display("[FAIL] %s exp %h got %h",name,w,s);
endtask
task wrap_up;
  if (n_mismatch==0&&n_checks>0) $display("Run complete: PASS");
  else $display("Run complete: FAIL");
  $finish;
endtask
always @(posedge clk_sys) if (reset_n) begin
  m=!v[0]?v[7:4]:(v[2:1]==0)?(v[3]?m+1:m-1):m;
  e.push_back(m);
end
always @(negedge clk_sys) if (e.size()) begin
  #1;
  x=e.pop_front();
  chk("count",q,x);
  chk("flag",t,!(!v[2]&&x==(v[3]?4'hF:4'h0)));
end
initial begin
  repeat(3) @(negedge clk_sys);
  reset_n=1;
  repeat(400) @(negedge clk_sys);
  wrap_up;
end
initial begin
  #15000 n_mismatch++;
  wrap_up;
end
endmodule // tb_puc_counter

// ==== design/puc_counter.v ====
`timescale 1ns/10ps
`include "puc_defines.vh"
module puc_counter #(
  parameter WIDTH = `PUC_WIDTH
) (
  input wire clk_sys,
  input wire reset_n,
  input wire load_n,
  input wire count_gate_parallel_n,
  input wire count_gate_carry_n,
  input wire count_up,
  input wire [WIDTH-1:0] preset_inputs,
  output wire [WIDTH-1:0] count_value,
  output wire terminal_flag_n
);

  // ---------------------------------------------------------------
  // Mode codes.
  // ---------------------------------------------------------------
  localparam [1:0] MODE_HOLD = 2'h0;
  localparam [1:0] MODE_LOAD = 2'h1;
  localparam [1:0] MODE_UP = 2'h2;
  localparam [1:0] MODE_DOWN = 2'h3;

  // ---------------------------------------------------------------
  // Count constants.
  // ---------------------------------------------------------------
  localparam [WIDTH-1:0] RESET_VALUE = `PUC_RESET_VALUE;
  localparam [WIDTH-1:0] TERM_UP = `PUC_TERM_UP;
  localparam [WIDTH-1:0] TERM_DOWN = `PUC_TERM_DOWN;

  // ---------------------------------------------------------------
  // Input qualifiers.
  // ---------------------------------------------------------------
  wire load_req;
  wire gate_par;
  wire gate_carry;
  wire count_en;
  wire dir_up;

  assign load_req = ~load_n;
  assign gate_par = ~count_gate_parallel_n;
  assign gate_carry = ~count_gate_carry_n;
  assign count_en = gate_par & gate_carry & ~load_req;
  assign dir_up = count_up;

  // ---------------------------------------------------------------
  // Mode decode.
  // ---------------------------------------------------------------
  reg [1:0] mode_sel;

  always @* begin
    mode_sel = MODE_HOLD;
    if (load_req) begin
      mode_sel = MODE_LOAD;
    end else if (count_en) begin
      if (dir_up) begin
        mode_sel = MODE_UP;
      end else begin
        mode_sel = MODE_DOWN;
      end
    end else begin
      mode_sel = MODE_HOLD;
    end
  end

  // ---------------------------------------------------------------
  // Step chains.
  // ---------------------------------------------------------------
  wire [WIDTH-1:0] count_q;
  wire [WIDTH-1:0] up_carry;
  wire [WIDTH-1:0] down_borrow;
  wire [WIDTH-1:0] sum_up;
  wire [WIDTH-1:0] sum_down;

  assign up_carry[0] = 1'h1;
  assign down_borrow[0] = 1'h1;

  genvar gi;

  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_step
      assign sum_up[gi] = count_q[gi] ^ up_carry[gi];
      assign sum_down[gi] = count_q[gi] ^ down_borrow[gi];
      if (gi < WIDTH - 1) begin : g_chain
        assign up_carry[gi+1] = up_carry[gi] & count_q[gi];
        assign down_borrow[gi+1] = down_borrow[gi] & ~count_q[gi];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Bit cells.
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_cell
      puc_bit_cell #(
        .RESET_BIT(RESET_VALUE[gi])
      ) puc_bit_cell_inst (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .mode_sel(mode_sel),
        .preset_bit(preset_inputs[gi]),
        .up_bit(sum_up[gi]),
        .down_bit(sum_down[gi]),
        .bit_value(count_q[gi])
      );
    end
  endgenerate

  assign count_value = count_q;

  // ---------------------------------------------------------------
  // Terminal count decode.
  // ---------------------------------------------------------------
  wire [WIDTH:0] up_match;
  wire [WIDTH:0] down_match;
  wire term_up_hit;
  wire term_down_hit;
  wire term_hit;

  assign up_match[0] = 1'h1;
  assign down_match[0] = 1'h1;

  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_term
      assign up_match[gi+1] = up_match[gi] &
        (count_q[gi] == TERM_UP[gi]);
      assign down_match[gi+1] = down_match[gi] &
        (count_q[gi] == TERM_DOWN[gi]);
    end
  endgenerate

  assign term_up_hit = up_match[WIDTH];
  assign term_down_hit = down_match[WIDTH];
  assign term_hit = dir_up ? term_up_hit : term_down_hit;

  // ---------------------------------------------------------------
  // Terminal flag gating.
  // ---------------------------------------------------------------
  assign terminal_flag_n = ~(term_hit & gate_carry);

endmodule // puc_counter

module puc_bit_cell #(
  parameter RESET_BIT = 1'h0
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [1:0] mode_sel,
  input wire preset_bit,
  input wire up_bit,
  input wire down_bit,
  output wire bit_value
);

  // ---------------------------------------------------------------
  // Mode codes.
  // ---------------------------------------------------------------
  localparam [1:0] MODE_HOLD = 2'h0;
  localparam [1:0] MODE_LOAD = 2'h1;
  localparam [1:0] MODE_UP = 2'h2;
  localparam [1:0] MODE_DOWN = 2'h3;

  // ---------------------------------------------------------------
  // Bit state.
  // ---------------------------------------------------------------
  reg bit_r;
  reg bit_nxt;

  always @* begin
    bit_nxt = bit_r;
    case (mode_sel)
      MODE_LOAD: begin
        bit_nxt = preset_bit;
      end
      MODE_UP: begin
        bit_nxt = up_bit;
      end
      MODE_DOWN: begin
        bit_nxt = down_bit;
      end
      MODE_HOLD: begin
        bit_nxt = bit_r;
      end
      default: begin
        bit_nxt = bit_r;
      end
    endcase
  end

  // The reset only gives simulation a known value; a load sets the start.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_r <= RESET_BIT;
    end else begin
      bit_r <= bit_nxt;
    end
  end

  assign bit_value = bit_r;

endmodule // puc_bit_cell

// ==== design/puc_defines.vh ====
// Operation
// - All four bits update on rising edge.
// - Bits change together, never ripple.
// - Low load copies preset inputs regardless.
// - Load beats counting and holding.
// - Count only with both enables low.
// - Either enable high holds the count.
// - Direction high increments, low decrements.
// - Terminal flag low only when gated.
// - Up terminal at fifteen, all high.
// - Down terminal at zero, all low.
// - Carry enable feeds terminal flag combinationally.
// - Parallel enable never affects terminal flag.
// - Terminal flag decoded from stored state.
`ifndef PUC_DEFINES_VH
`define PUC_DEFINES_VH
`define PUC_WIDTH 4
`define PUC_TERM_UP 4'hF
`define PUC_TERM_DOWN 4'h0
`define PUC_STEP 4'h1
`define PUC_RESET_VALUE 4'h0
`endif
